// ==== shared/tlv_pkg.sv ====
// Constants for the two-level vectored interrupt unit.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
package tlv_pkg;
  // Number of interrupt sources in fixed order 0..18
  localparam int NSRC = 19;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_EXT_EN_ONE = 8'h04;
  localparam logic [7:0] OFS_EXT_EN_TWO = 8'h08;
  localparam logic [7:0] OFS_LEVEL = 8'h0c;
  localparam logic [7:0] OFS_EXT_LVL_ONE = 8'h10;
  localparam logic [7:0] OFS_EXT_LVL_TWO = 8'h14;
  localparam logic [7:0] OFS_PENDING = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // Global gate bit inside the enable register
  localparam int GATE_BIT = 7;
  // Source ranges covered by each enable or level register
  localparam int BASE_ONE = 7;
  localparam int BASE_TWO = 15;
  localparam int WIDTH_TWO = 4;
  // Sources whose pending flag hardware clears on vectoring
  localparam logic [18:0] AUTO_CLEAR = 19'h0000f;
  // Vector table: first vector and spacing in bytes
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_STEP_SHIFT = 3;
  // Long call takes 5 system clocks
  localparam int LONG_CALL_CYCLES = 5;
  // Reset values
  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // AHB transfer type bit 1 marks NONSEQ or SEQ
  localparam int HTRANS_ACTIVE_BIT = 1;
  // Controller states
  typedef enum logic [1:0] {
    tlv_run,
    tlv_call
  } tlv_state_e;
endpackage

// ==== src/tlv_unit.sv ====
// Two-level vectored interrupt unit with AHB-Lite register slave.
// Sources and core handshakes are on-chip logic on hclk; no syncs.
`timescale 1ns/100ps
module tlv_unit
  import tlv_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Peripheral interrupt conditions, one-cycle pulses
  input wire logic [tlv_pkg::NSRC-1:0] src_event,
  // Core handshake
  input wire logic instr_done,
  input wire logic return_from_interrupt_done,
  output logic irq_req,
  output logic long_call,
  output logic [15:0] vector_addr,
  output logic [1:0] in_service
);
  import tlv_pkg::*;

  // Software visible configuration
  logic [7:0] irq_enable_reg; // Bit 7 is the global gate
  logic [7:0] ext_enable_reg_one; // Sources 7..14
  logic [7:0] ext_enable_reg_two; // Sources 15..18 in low bits
  logic [7:0] irq_level_reg; // Sources 0..6
  logic [7:0] ext_level_reg_one;
  logic [7:0] ext_level_reg_two;
  logic [NSRC-1:0] pending; // Sticky pending flags
  logic [NSRC-1:0] next_pending;

  // Bus data phase capture
  logic wr_pend; // A write data phase follows
  logic [7:0] wr_ofs; // Its offset

  // Arbitration
  logic global_irq_gate;
  logic [NSRC-1:0] src_en; // Per-source enables
  logic [NSRC-1:0] src_hi; // Per-source level
  logic [NSRC-1:0] eligible;
  logic [NSRC-1:0] hi_req;
  logic [NSRC-1:0] lo_req;
  logic win_valid; // Registered winner, decoded each cycle
  logic [4:0] win_idx;
  logic win_hi;
  logic next_valid;
  logic [4:0] next_idx;
  logic next_hi;

  // Sequencing
  tlv_state_e state;
  logic [2:0] call_cnt; // Remaining long call cycles
  logic hi_act; // High level routine in service
  logic lo_act; // Low level routine in service
  logic do_call; // Vectoring this cycle

  // Lowest set index of a vector
  function automatic logic [4:0] first_set(input logic [NSRC-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Map enable and level registers onto source order
  always_comb begin
    global_irq_gate = irq_enable_reg[GATE_BIT];
    src_en = {ext_enable_reg_two[WIDTH_TWO-1:0],
              ext_enable_reg_one,
              irq_enable_reg[BASE_ONE-1:0]};
    src_hi = {ext_level_reg_two[WIDTH_TWO-1:0],
              ext_level_reg_one,
              irq_level_reg[BASE_ONE-1:0]};
  end

  // Requests allowed by gate, enables and service markers
  always_comb begin
    // gated flags simply wait in pending
    eligible = global_irq_gate ? (pending & src_en) : '0;
    // nothing passes while high is in service
    hi_req = hi_act ? '0 : (eligible & src_hi);
    lo_req = (hi_act || lo_act) ? '0 : (eligible & ~src_hi);
    // high level first, then lowest order
    next_valid = (|hi_req) || (|lo_req);
    next_hi = |hi_req;
    next_idx = (|hi_req) ? first_set(hi_req) : first_set(lo_req);
  end

  // decode sampled each cycle, one detect clock
  // Registering the winner costs the one detect clock,
  // but it keeps the arbiter off the call path.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_valid <= 1'b0;
      win_idx <= 5'h00;
      win_hi <= 1'b0;
      irq_req <= 1'b0;
    end else begin
      win_valid <= next_valid;
      win_idx <= next_idx;
      win_hi <= next_hi;
      irq_req <= next_valid;
    end
  end

  // vector when the running instruction completes
  // the return itself is not a completion point
  // a long instruction only delays instr_done
  // Limitation: response grows with the running instruction.
  assign do_call = (state == tlv_run) && win_valid &&
                   instr_done && !return_from_interrupt_done;

  // Controller state: run or long call in progress
  // The call window ignores completions, so a core that is
  // still busy cannot start a second call before the first ends.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= tlv_run;
      call_cnt <= 3'h0;
    end else begin
      case (state)
        tlv_run: begin
          if (do_call) begin
            state <= tlv_call;
            call_cnt <= 3'(LONG_CALL_CYCLES - 1);
          end
        end
        tlv_call: begin
          // Core is busy with the call; completions ignored
          if (call_cnt == 3'h1) begin
            state <= tlv_run;
          end
          call_cnt <= call_cnt - 3'h1;
        end
        default: begin
          state <= tlv_run;
          call_cnt <= 3'h0;
        end
      endcase
    end
  end

  // Long call strobe and vector address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      long_call <= 1'b0;
      vector_addr <= 16'h0000;
    end else begin
      long_call <= do_call;
      if (do_call) begin
        // base plus eight bytes per order
        vector_addr <= VEC_BASE +
                       (16'(win_idx) << VEC_STEP_SHIFT);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_act <= 1'b0;
      lo_act <= 1'b0;
    end else if (do_call) begin
      if (win_hi) begin
        hi_act <= 1'b1;
      end else begin
        lo_act <= 1'b1;
      end
    end else if (return_from_interrupt_done) begin
      if (hi_act) begin
        hi_act <= 1'b0;
      end else begin
        lo_act <= 1'b0;
      end
    end
  end

  // Service markers as seen by the core
  // Trade-off: registered for timing, so they lag the
  // internal markers by one clock.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_service <= 2'b00;
    end else begin
      in_service <= {hi_act, lo_act};
    end
  end

  // Pending flags: software write, auto clear, then events
  always_comb begin
    next_pending = pending;
    // Software write replaces the whole word; events win below
    // software writes act like real events
    if (wr_pend && wr_ofs == OFS_PENDING) begin
      next_pending = hwdata[NSRC-1:0];
    end
    // auto clear of the four timer/edge flags
    if (do_call && AUTO_CLEAR[win_idx]) begin
      next_pending[win_idx] = 1'b0;
    end
    // events set regardless of enables; set wins
    // a flag left set requests again at once
    next_pending = next_pending | src_event;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending <= '0;
    end else begin
      pending <= next_pending;
    end
  end

  // Bus address phase capture; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
    end else if (hready) begin
      wr_pend <= hsel && htrans[HTRANS_ACTIVE_BIT] && hwrite;
      wr_ofs <= haddr[7:0];
    end
  end

  // Configuration writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable_reg <= REG8_RESET;
      ext_enable_reg_one <= REG8_RESET;
      ext_enable_reg_two <= REG8_RESET;
      irq_level_reg <= REG8_RESET;
      ext_level_reg_one <= REG8_RESET;
      ext_level_reg_two <= REG8_RESET;
    end else if (wr_pend) begin
      case (wr_ofs)
        OFS_ENABLE: irq_enable_reg <= hwdata[7:0];
        OFS_EXT_EN_ONE: ext_enable_reg_one <= hwdata[7:0];
        OFS_EXT_EN_TWO: ext_enable_reg_two <= hwdata[7:0];
        OFS_LEVEL: irq_level_reg <= hwdata[7:0];
        OFS_EXT_LVL_ONE: ext_level_reg_one <= hwdata[7:0];
        OFS_EXT_LVL_TWO: ext_level_reg_two <= hwdata[7:0];
        // Unmapped or read-only: write dropped
        default: begin
        end
      endcase
    end
  end

  // Read data registered at the address phase edge; a read
  // right behind a write would be stale, but single
  // transfers always close the write first.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= WORD_ZERO;
    end else if (hready && hsel && htrans[HTRANS_ACTIVE_BIT]
                 && !hwrite) begin
      case (haddr[7:0])
        OFS_ENABLE: hrdata <= {24'h0, irq_enable_reg};
        OFS_EXT_EN_ONE: hrdata <= {24'h0, ext_enable_reg_one};
        OFS_EXT_EN_TWO: hrdata <= {24'h0, ext_enable_reg_two};
        OFS_LEVEL: hrdata <= {24'h0, irq_level_reg};
        OFS_EXT_LVL_ONE: hrdata <= {24'h0, ext_level_reg_one};
        OFS_EXT_LVL_TWO: hrdata <= {24'h0, ext_level_reg_two};
        OFS_PENDING: hrdata <= {13'h0, pending};
        // Status: winner, level markers, request
        // Bit 0 winner valid, bit 1 spare, bit 2 low marker,
        // bit 3 high marker, bit 4 winner level, bits 9:5 index
        OFS_STATUS: hrdata <= {22'h0, win_idx, win_hi,
                               hi_act, lo_act, 1'b0,
                               win_valid};
        default: hrdata <= WORD_ZERO;
      endcase
    end
  end

  // Always ready, always OKAY
  // Registered so that every top output leaves a flip-flop;
  // the slave never stretches a transfer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule

// ==== test/tlv_core_model.sv ====
// Core model: completes one instruction per cycle (or every other one).
// Assumes long_call seen one cycle and return_from_interrupt requested by the bench.
`timescale 1ns/100ps
module tlv_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic long_call,
  input wire logic return_from_interrupt_go,
  input wire logic slow,
  output logic instr_done,
  output logic return_from_interrupt_done
);
  logic [2:0] busy; // Cycles left of the long call
  logic ph; // Half-rate phase for slow mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 3'h0;
      ph <= 1'b0;
    end else begin
      ph <= !ph;
      busy <= long_call ? 3'h5 : (busy != 3'h0 ? busy - 3'h1 : 3'h0);
    end
  end
  // every enabled vector holds a routine
  // return completes instead of an instruction
  assign return_from_interrupt_done = return_from_interrupt_go && busy == 3'h0 && hresetn;
  assign instr_done = !return_from_interrupt_go && busy == 3'h0 && (!slow || ph) && hresetn;
endmodule

// ==== test/tlv_unit_sva.sv ====
// Checker for the interrupt unit core-side outputs.
// Assumes one clock hclk and async active-low hresetn.
`timescale 1ns/100ps
module tlv_unit_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic instr_done,
  input wire logic return_from_interrupt_done,
  input wire logic irq_req,
  input wire logic long_call,
  input wire logic [15:0] vector_addr,
  input wire logic [1:0] in_service,
  input wire logic hreadyout,
  input wire logic hresp
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A call and the quiet span it occupies
  sequence s_call;
    long_call;
  endsequence
  sequence s_quiet;
    !long_call [*4];
  endsequence
  a_call_quiet: assert property (s_call |=> s_quiet)
    else $error("call repeated inside its own span");
  a_call_done: assert property (long_call |-> $past(instr_done) && !$past(return_from_interrupt_done))
    else $error("call without a completed instruction");
  a_call_req: assert property (long_call |-> $past(irq_req))
    else $error("call without a request");
  a_vector_form: assert property (long_call |-> vector_addr[2:0] == 3'h3 && vector_addr <= 16'h0093)
    else $error("vector off the table");
  a_vector_hold: assert property (!long_call |-> $stable(vector_addr))
    else $error("vector moved without a call");
  a_svc_marked: assert property (long_call |=> in_service != 2'b00)
    else $error("no level marked after call");
  a_high_blocks: assert property (in_service[1] |-> !long_call)
    else $error("high routine preempted");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule
bind tlv_unit tlv_unit_sva chk_u (.hclk(hclk), .hresetn(hresetn), .instr_done(instr_done),
  .return_from_interrupt_done(return_from_interrupt_done), .irq_req(irq_req), .long_call(long_call),
  .vector_addr(vector_addr), .in_service(in_service), .hreadyout(hreadyout), .hresp(hresp));

// ==== test/two_level_vectored_interrupt_unit_tb.sv ====
// Bench: bus tasks set up sources, the core model answers calls.
// Assumes the unit's register map and timing in its package.
`timescale 1ns/100ps
module two_level_vectored_interrupt_unit_tb;
  import tlv_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, return_from_interrupt_go = 0, slow = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0, in_service;
  logic [18:0] src_event = '0;
  logic hreadyout, hresp, instr_done, return_from_interrupt_done, irq_req, long_call;
  logic [15:0] vector_addr;
  int n_fail = 0, samples_checked = 0;
  tlv_unit dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_event(src_event),
    .instr_done(instr_done), .return_from_interrupt_done(return_from_interrupt_done), .irq_req(irq_req),
    .long_call(long_call), .vector_addr(vector_addr), .in_service(in_service));
  tlv_core_model core_u (.hclk(hclk), .hresetn(hresetn), .long_call(long_call),
    .return_from_interrupt_go(return_from_interrupt_go), .slow(slow), .instr_done(instr_done), .return_from_interrupt_done(return_from_interrupt_done));
  initial forever #4 hclk = ~hclk;
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Single AHB transfer; read data left in r
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  // One-cycle source pulse; returns at its sampling edge
  task pulse(input int s);
    @(posedge hclk);
    src_event <= 19'h1 << s;
    @(posedge hclk);
    src_event <= '0;
  endtask
  task wcall(output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (long_call !== 1'b1 && n < 80);
  endtask
  // Wait for a call, then check vector, pending flags, markers
  task svc(input logic [15:0] v, input logic [31:0] p, input logic [1:0] s);
    int n;
    wcall(n);
    chk({31'h0, long_call}, 32'h1);
    chk({16'h0, vector_addr}, {16'h0, v});
    rdc(OFS_PENDING, p);
    chk({30'h0, in_service}, {30'h0, s});
  endtask
  task return_from_interrupt;
    repeat (6) @(posedge hclk);
    return_from_interrupt_go <= 1'b1;
    @(posedge hclk);
    return_from_interrupt_go <= 1'b0;
  endtask
  task quiet(input int k);
    repeat (k) begin
      @(posedge hclk);
      chk({31'h0, long_call}, 32'h0);
    end
  endtask
  initial begin
    int n;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({12'h0, irq_req, long_call, in_service, vector_addr}, 32'h0);
    // Reset values, unmapped word included
    for (int a = 0; a < 36; a += 4) rdc(a[7:0], 32'h0);
    bus(1'b1, OFS_ENABLE, 32'h7f);
    bus(1'b1, OFS_EXT_EN_ONE, 32'hff);
    bus(1'b1, OFS_EXT_EN_TWO, 32'hf);
    pulse(2);
    quiet(8);
    rdc(OFS_PENDING, 32'h4);
    bus(1'b1, OFS_ENABLE, 32'hff);
    svc(16'h0013, 32'h0, 2'b01);
    return_from_interrupt;
    pulse(1);
    wcall(n);
    chk(n, 3);
    chk({16'h0, vector_addr}, 32'h000b);
    return_from_interrupt;
    slow <= 1'b1;
    pulse(0);
    wcall(n);
    chk({31'h0, n <= 4}, 32'h1);
    return_from_interrupt;
    for (int i = 0; i < 19; i++) begin
      bus(1'b1, OFS_PENDING, 32'h1 << i);
      svc(VEC_BASE + 16'(i * 8), i < 4 ? 32'h0 : 32'h1 << i, 2'b01);
      bus(1'b1, OFS_PENDING, 32'h0);
      return_from_interrupt;
    end
    slow <= 1'b0;
    bus(1'b1, OFS_PENDING, 32'h28);
    svc(16'h001b, 32'h20, 2'b01);
    return_from_interrupt;
    svc(16'h002b, 32'h20, 2'b01);
    bus(1'b1, OFS_PENDING, 32'h0);
    return_from_interrupt;
    bus(1'b1, OFS_LEVEL, 32'h20);
    bus(1'b1, OFS_PENDING, 32'h28);
    svc(16'h002b, 32'h28, 2'b10);
    quiet(12);
    bus(1'b1, OFS_PENDING, 32'h8);
    return_from_interrupt;
    svc(16'h001b, 32'h0, 2'b01);
    pulse(5);
    svc(16'h002b, 32'h20, 2'b11);
    bus(1'b1, OFS_PENDING, 32'h0);
    return_from_interrupt;
    repeat (3) @(posedge hclk);
    chk({30'h0, in_service}, 32'h1);
    return_from_interrupt;
    repeat (3) @(posedge hclk);
    chk({30'h0, in_service}, 32'h0);
    bus(1'b1, OFS_STATUS, 32'hffffffff);
    rdc(OFS_STATUS, 32'h0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(OFS_ENABLE, 32'h0);
    final_report;
  end
  // Hang guard, far beyond the expected run
  initial begin
    #200000;
    n_fail++;
    final_report;
  end
endmodule
